/* File: include/pacing_pkg.sv */
package pacing_pkg;
    localparam int SAMPLE_W = 16;
    localparam int MINUTE_W = 16;
    localparam int ACC_W = 48;
    localparam int NSRC = 8;
    localparam int SRC_W = 3;

    // Register byte offsets on the APB bus.
    localparam logic [7:0] MODE_OFS = 8'h00;
    localparam logic [7:0] FLOW_QUANTITY_PACING_OFS = 8'h04;
    localparam logic [7:0] MAXFLOW_OFS = 8'h08;
    localparam logic [7:0] COND_A_OFS = 8'h0C;
    localparam logic [7:0] COND_B_OFS = 8'h10;
    localparam logic [7:0] LIMIT_A_OFS = 8'h14;
    localparam logic [7:0] LIMIT_B_OFS = 8'h18;
    localparam logic [7:0] SLOPE_T_OFS = 8'h1C;
    localparam logic [7:0] INTERVAL_OFS = 8'h20;
    localparam logic [7:0] STATUS_OFS = 8'h24;

    // Field positions.
    localparam int MODE_LSB = 0;
    localparam int COMB_LSB = 2;
    localparam int HOST_LOCK_BIT = 4;
    localparam int CSRC_LSB = 0;
    localparam int CCMP_LSB = 4;
    localparam int TRUE_IV_LSB = 0;
    localparam int FALSE_IV_LSB = 16;

    // Reset values.
    localparam logic [31:0] MODE_RST = 32'h0000_0000;
    localparam logic [31:0] FLOW_QUANTITY_PACING_RST = 32'h0000_0001;
    localparam logic [31:0] MAXFLOW_RST = 32'h0000_0001;
    localparam logic [31:0] ZERO_RST = 32'h0000_0000;

    // Sources: 3 = oxygen, 4 = acidity.
    localparam logic [SRC_W-1:0] SRC_OXY = 3'h3;
    localparam logic [SRC_W-1:0] SRC_ACID = 3'h4;

    // Timing: one minute at 200 MHz.
    localparam int CLK_MHZ = 200;
    localparam longint MINUTE_S = 60;
    localparam longint MINUTE_CYC = MINUTE_S * CLK_MHZ * 1000000;

    typedef enum logic [1:0] {
        PACE_OFF = 2'h0,
        PACE_FLOW_QUANTITY_PACING = 2'h1,
        PACE_HOST = 2'h2,
        PACE_COND = 2'h3
    } pace_mode_t;

    typedef enum logic [1:0] {
        COMB_DONE = 2'h0,
        COMB_OR = 2'h1,
        COMB_AND = 2'h2
    } comb_t;

    typedef enum logic [1:0] {
        CMP_GT = 2'h0,
        CMP_LT = 2'h1,
        CMP_SLOPE = 2'h2
    } cmp_t;

    typedef struct packed {
        logic [SRC_W-1:0] src;
        cmp_t cmp;
        logic [SAMPLE_W-1:0] limit;
    } cond_cfg_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;
endpackage : pacing_pkg

/* File: hdl/sampler_pacing.sv */
`timescale 1ns/10ps
module sampler_pacing #(
    parameter longint MINUTE_CYCLES = pacing_pkg::MINUTE_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire pacing_pkg::apb_req_t apb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic host_write,
    input wire logic [7:0] host_addr,
    input wire logic [31:0] host_wdata,
    input wire logic level_only,
    input wire logic [pacing_pkg::NSRC-1:0] sensor_enabled,
    input wire logic [pacing_pkg::NSRC*pacing_pkg::SAMPLE_W-1:0] samples,
    input wire logic flow_tick,
    input wire logic [31:0] flow_amount,
    output logic flow_pulse
);
    localparam int SW = pacing_pkg::SAMPLE_W;

    logic [31:0] mode_ff, flow_quantity_pacing_ff, maxflow_ff, cond_a_ff, cond_b_ff;
    logic [31:0] limit_a_ff, limit_b_ff, slope_t_ff, interval_ff;
    logic [pacing_pkg::ACC_W-1:0] acc_ff;
    logic [39:0] tick_ff;
    logic [pacing_pkg::MINUTE_W-1:0] minutes_ff;
    logic [SW-1:0] base_a_ff, base_b_ff;
    logic [pacing_pkg::MINUTE_W-1:0] slope_min_ff;
    logic comb_prev_ff;
    logic pulse_ff;
    logic [31:0] rdata_ff;

    // Bus and host write paths.
    wire bus_wr = apb.psel & apb.penable & apb.pwrite;
    wire bus_rd = apb.psel & apb.penable & ~apb.pwrite;
    wire host_locked = mode_ff[pacing_pkg::HOST_LOCK_BIT];
    wire local_wr = bus_wr & ~host_locked;
    wire wr_en = local_wr | host_write;
    wire [7:0] wr_addr = host_write ? host_addr : apb.paddr;
    wire [31:0] wr_data = host_write ? host_wdata : apb.pwdata;
    wire addr_ok = (apb.paddr <= pacing_pkg::STATUS_OFS) && (apb.paddr[1:0] == 2'h0);

    assign pready = 1'b1;
    assign pslverr = apb.psel & apb.penable & (~addr_ok | (bus_wr & host_locked));

    // Written mode and combiner; an illegal pacing mode choice refuses the whole word, combiner included, else the word is taken as written.
    wire [1:0] mode_req = wr_data[pacing_pkg::MODE_LSB +: 2];
    wire vol_refused = (mode_req == pacing_pkg::PACE_FLOW_QUANTITY_PACING) & level_only;
    wire host_refused = (mode_req == pacing_pkg::PACE_HOST) & ~host_write;
    wire [31:0] mode_new = (vol_refused | host_refused) ? mode_ff : wr_data;

    // Pacing flow_quantity_pacing clamp to max/10 .. max*10000.
    wire [47:0] vol_lo = {16'h0000, maxflow_ff / 32'd10};
    wire [47:0] vol_hi = maxflow_ff * 48'd10000;
    wire [47:0] vol_w = {16'h0000, wr_data};
    wire [47:0] vol_c = (vol_w < vol_lo) ? vol_lo : ((vol_w > vol_hi) ? vol_hi : vol_w);
    wire [47:0] vol_eff = (vol_c == 48'h0) ? 48'h1 : vol_c;

    // A condition may pick only an enabled sensor, never oxygen with acidity.
    function automatic logic [31:0] cond_check(input logic [31:0] d, input logic [31:0] other,
                                               input logic [pacing_pkg::NSRC-1:0] en);
        logic [2:0] s;
        logic [2:0] o;
        logic clash;
        s = d[pacing_pkg::CSRC_LSB +: 3];
        o = other[pacing_pkg::CSRC_LSB +: 3];
        clash = ((s == pacing_pkg::SRC_OXY) && (o == pacing_pkg::SRC_ACID))
              || ((s == pacing_pkg::SRC_ACID) && (o == pacing_pkg::SRC_OXY));
        cond_check = (en[s] && !clash) ? d : other;
    endfunction : cond_check

    wire [31:0] cond_a_new = cond_check(wr_data, cond_b_ff, sensor_enabled) == wr_data ? wr_data : cond_a_ff;
    wire [31:0] cond_b_new = cond_check(wr_data, cond_a_ff, sensor_enabled) == wr_data ? wr_data : cond_b_ff;

    always_ff @(posedge clock) begin
        if (rst) begin
            mode_ff <= pacing_pkg::MODE_RST;
            flow_quantity_pacing_ff <= pacing_pkg::FLOW_QUANTITY_PACING_RST;
            maxflow_ff <= pacing_pkg::MAXFLOW_RST;
            cond_a_ff <= pacing_pkg::ZERO_RST;
            cond_b_ff <= pacing_pkg::ZERO_RST;
            limit_a_ff <= pacing_pkg::ZERO_RST;
            limit_b_ff <= pacing_pkg::ZERO_RST;
            slope_t_ff <= pacing_pkg::ZERO_RST;
            interval_ff <= pacing_pkg::ZERO_RST;
        end else if (ce && wr_en) begin
            unique case (wr_addr)
                pacing_pkg::MODE_OFS: mode_ff <= mode_new;
                pacing_pkg::FLOW_QUANTITY_PACING_OFS: flow_quantity_pacing_ff <= vol_eff[31:0];
                pacing_pkg::MAXFLOW_OFS: maxflow_ff <= wr_data;
                pacing_pkg::COND_A_OFS: cond_a_ff <= cond_a_new;
                pacing_pkg::COND_B_OFS: cond_b_ff <= cond_b_new;
                pacing_pkg::LIMIT_A_OFS: limit_a_ff <= wr_data;
                pacing_pkg::LIMIT_B_OFS: limit_b_ff <= wr_data;
                pacing_pkg::SLOPE_T_OFS: slope_t_ff <= wr_data;
                pacing_pkg::INTERVAL_OFS: interval_ff <= wr_data;
                default: ;
            endcase
        end
    end

    // Condition evaluation.
    wire [1:0] pmode = mode_ff[pacing_pkg::MODE_LSB +: 2];
    wire [1:0] comb = mode_ff[pacing_pkg::COMB_LSB +: 2];
    wire [2:0] src_a = cond_a_ff[pacing_pkg::CSRC_LSB +: 3];
    wire [2:0] src_b = cond_b_ff[pacing_pkg::CSRC_LSB +: 3];
    wire [1:0] cmp_a = cond_a_ff[pacing_pkg::CCMP_LSB +: 2];
    wire [1:0] cmp_b = cond_b_ff[pacing_pkg::CCMP_LSB +: 2];
    wire [SW-1:0] meas_a = samples[src_a*SW +: SW];
    wire [SW-1:0] meas_b = samples[src_b*SW +: SW];
    wire [SW-1:0] lim_a = limit_a_ff[SW-1:0];
    wire [SW-1:0] lim_b = limit_b_ff[SW-1:0];
    wire [SW-1:0] diff_a = (meas_a > base_a_ff) ? meas_a - base_a_ff : base_a_ff - meas_a;
    wire [SW-1:0] diff_b = (meas_b > base_b_ff) ? meas_b - base_b_ff : base_b_ff - meas_b;

    function automatic logic met(input logic [1:0] c, input logic [SW-1:0] m,
                                 input logic [SW-1:0] l, input logic [SW-1:0] d);
        met = 1'b0;
        unique case (c)
            pacing_pkg::CMP_GT: met = m > l;
            pacing_pkg::CMP_LT: met = m < l;
            pacing_pkg::CMP_SLOPE: met = d >= l;
            default: met = 1'b0;
        endcase
    endfunction : met

    wire met_a = met(cmp_a, meas_a, lim_a, diff_a);
    wire met_b = met(cmp_b, meas_b, lim_b, diff_b);
    wire comb_true = (comb == pacing_pkg::COMB_OR) ? (met_a | met_b)
                   : (comb == pacing_pkg::COMB_AND) ? (met_a & met_b)
                   : met_a;

    // Minute timer and interval selection.
    wire [15:0] true_iv = interval_ff[pacing_pkg::TRUE_IV_LSB +: 16];
    wire [15:0] false_iv = interval_ff[pacing_pkg::FALSE_IV_LSB +: 16];
    wire [15:0] act_iv = comb_true ? true_iv : false_iv;
    wire minute_done = (tick_ff == 40'(MINUTE_CYCLES - 1));
    wire cond_mode = (pmode == pacing_pkg::PACE_COND) | (pmode == pacing_pkg::PACE_HOST);
    wire changed = comb_true != comb_prev_ff;
    wire iv_pulse = cond_mode & minute_done & (act_iv != 16'h0) & (minutes_ff + 16'h1 >= act_iv);
    wire [15:0] slope_t = slope_t_ff[15:0];
    wire slope_end = minute_done & (slope_min_ff + 16'h1 >= slope_t);

    // Flow_quantity_pacing accumulation.
    wire [47:0] acc_sum = acc_ff + {16'h0000, flow_amount};
    wire vol_pulse = (pmode == pacing_pkg::PACE_FLOW_QUANTITY_PACING) & flow_tick & (acc_sum >= {16'h0000, flow_quantity_pacing_ff});

    always_ff @(posedge clock) begin
        if (rst) begin
            tick_ff <= 40'h00_0000_0000;
            minutes_ff <= 16'h0000;
            comb_prev_ff <= 1'b0;
            acc_ff <= 48'h0000_0000_0000;
            slope_min_ff <= 16'h0000;
            base_a_ff <= '0;
            base_b_ff <= '0;
            pulse_ff <= 1'b0;
        end else if (ce) begin
            comb_prev_ff <= comb_true;
            if (changed || !cond_mode) begin
                tick_ff <= 40'h00_0000_0000;
                minutes_ff <= 16'h0000;
            end else if (minute_done) begin
                tick_ff <= 40'h00_0000_0000;
                minutes_ff <= iv_pulse ? 16'h0000 : minutes_ff + 16'h1;
            end else begin
                tick_ff <= tick_ff + 40'h1;
            end
            if (slope_end) begin
                slope_min_ff <= 16'h0000;
                base_a_ff <= meas_a;
                base_b_ff <= meas_b;
            end else if (minute_done) begin
                slope_min_ff <= slope_min_ff + 16'h1;
            end
            if (pmode != pacing_pkg::PACE_FLOW_QUANTITY_PACING) begin
                acc_ff <= 48'h0000_0000_0000;
            end else if (flow_tick) begin
                acc_ff <= vol_pulse ? acc_sum - {16'h0000, flow_quantity_pacing_ff} : acc_sum;
            end
            pulse_ff <= (pmode != pacing_pkg::PACE_OFF) & (vol_pulse | iv_pulse);
        end else begin
            pulse_ff <= 1'b0;
        end
    end

    assign flow_pulse = pulse_ff;

    // Read data.
    wire [31:0] status_word = {29'h0, host_locked, comb_true, pulse_ff};
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (apb.paddr)
            pacing_pkg::MODE_OFS: rd_mux = mode_ff;
            pacing_pkg::FLOW_QUANTITY_PACING_OFS: rd_mux = flow_quantity_pacing_ff;
            pacing_pkg::MAXFLOW_OFS: rd_mux = maxflow_ff;
            pacing_pkg::COND_A_OFS: rd_mux = cond_a_ff;
            pacing_pkg::COND_B_OFS: rd_mux = cond_b_ff;
            pacing_pkg::LIMIT_A_OFS: rd_mux = limit_a_ff;
            pacing_pkg::LIMIT_B_OFS: rd_mux = limit_b_ff;
            pacing_pkg::SLOPE_T_OFS: rd_mux = slope_t_ff;
            pacing_pkg::INTERVAL_OFS: rd_mux = interval_ff;
            pacing_pkg::STATUS_OFS: rd_mux = status_word;
            default: rd_mux = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            rdata_ff <= 32'h0000_0000;
        end else if (ce && apb.psel && !apb.penable && !apb.pwrite) begin
            rdata_ff <= rd_mux;
        end
    end
    assign prdata = bus_rd ? rdata_ff : 32'h0000_0000;
endmodule : sampler_pacing

/* File: tb/pulse_sampler.sv */
`timescale 1ns/10ps
module pulse_sampler #(
    parameter int COUNTS = 4
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic flow_pulse
);
    int pulses;
    int taken;
    // Every pulse is one count; a sample is taken each time the count reaches its target.
    always @(posedge clock) begin
        if (rst) begin
            pulses <= 0;
            taken <= 0;
        end else if (flow_pulse === 1'b1) begin
            pulses <= pulses + 1;
            if ((pulses + 1) % COUNTS == 0) taken <= taken + 1;
        end
    end
endmodule : pulse_sampler

/* File: tb/pacing_checker.sv */
`timescale 1ns/10ps
module pacing_checker (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire pacing_pkg::apb_req_t apb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic flow_pulse
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    wire acc = apb.psel & apb.penable;
    wire good = (apb.paddr <= 8'h24) && (apb.paddr[1:0] == 2'h0);
    property p_ready; pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_err_phase; !acc |-> !pslverr; endproperty
    a_err_phase: assert property (p_err_phase) else $error("pslverr outside access");
    property p_rdata_idle; !(acc && !apb.pwrite) |-> prdata == 32'h0; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero when idle");
    property p_unmapped; acc && apb.paddr > 8'h24 |-> pslverr && prdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_unaligned; acc && apb.paddr[1:0] != 2'h0 |-> pslverr; endproperty
    a_unaligned: assert property (p_unaligned) else $error("unaligned access not refused");
    property p_mapped_read; acc && !apb.pwrite && good |-> !pslverr; endproperty
    a_mapped_read: assert property (p_mapped_read) else $error("mapped read refused");
    property p_ce_quiet; !ce |=> !flow_pulse; endproperty
    a_ce_quiet: assert property (p_ce_quiet) else $error("pulse while frozen");
    property p_rst_quiet; $fell(rst) |-> !flow_pulse; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("pulse after reset");
    c_pulse: cover property (flow_pulse);
    c_refused: cover property (acc && pslverr);
    c_read: cover property (acc && !apb.pwrite && good);
endmodule : pacing_checker

bind sampler_pacing pacing_checker chk_u (.clock(clock), .rst(rst), .ce(ce), .apb(apb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flow_pulse(flow_pulse));

/* File: tb/sampler_pacing_pulse_logic_tb.sv */
`timescale 1ns/10ps
module sampler_pacing_pulse_logic_tb;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    pacing_pkg::apb_req_t apb = '0;
    logic host_write = 1'b0;
    logic [7:0] host_addr = 8'h00;
    logic [31:0] host_wdata = 32'h0;
    logic level_only = 1'b0;
    logic [7:0] sensor_enabled = 8'h00;
    logic [127:0] samples = '0;
    logic flow_tick = 1'b0;
    logic [31:0] flow_amount = 32'h0;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire flow_pulse;
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;
    int base;
    logic [31:0] q;
    logic [31:0] iv [4] = '{32'h2, 32'h2, 32'h20000, 32'h20000};
    always #2.5 clock = ~clock;
    sampler_pacing #(.MINUTE_CYCLES(10)) dut_u (.clock(clock), .rst(rst), .ce(ce), .apb(apb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .host_write(host_write), .host_addr(host_addr),
        .host_wdata(host_wdata), .level_only(level_only), .sensor_enabled(sensor_enabled), .samples(samples),
        .flow_tick(flow_tick), .flow_amount(flow_amount), .flow_pulse(flow_pulse));
    pulse_sampler #(.COUNTS(4)) smp_u (.clock(clock), .rst(rst), .flow_pulse(flow_pulse));
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            close_out();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_checks++;
        if (g !== x) begin
            mismatches++;
            $display("Error t=%0t got %h exp %h", $time, g, x);
        end
    endtask : chk
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, input logic xe, output logic [31:0] r);
        @(posedge clock);
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clock);
        apb.penable <= 1'b1;
        // Hold the request until pready is seen high at a rising edge.
        do @(posedge clock); while (pready !== 1'b1);
        r = prdata;
        chk({31'h0, pslverr}, {31'h0, xe});
        apb <= '0;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d, 1'b0, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        xfer(a, 1'b0, 32'h0, 1'b0, q);
        chk(q, x);
    endtask : rd
    task automatic ticks(input int n, input logic [31:0] amt);
        @(posedge clock);
        flow_tick <= 1'b1;
        flow_amount <= amt;
        repeat (n) @(posedge clock);
        flow_tick <= 1'b0;
        repeat (4) @(posedge clock);
    endtask : ticks
    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        rd(pacing_pkg::MODE_OFS, 32'h0);
        rd(pacing_pkg::FLOW_QUANTITY_PACING_OFS, 32'h1);
        rd(pacing_pkg::MAXFLOW_OFS, 32'h1);
        xfer(8'h28, 1'b0, 32'h0, 1'b1, q);
        chk(q, 32'h0);
        base = smp_u.pulses;
        ticks(6, 32'h14);
        chk(32'(smp_u.pulses - base), 32'h0);
        ce <= 1'b0;
        @(posedge clock);
        ce <= 1'b1;
        level_only <= 1'b1;
        wr(pacing_pkg::MODE_OFS, 32'h1);
        rd(pacing_pkg::MODE_OFS, 32'h0);
        level_only <= 1'b0;
        $display("test reset and refusals done");
        wr(pacing_pkg::MAXFLOW_OFS, 32'h64);
        wr(pacing_pkg::FLOW_QUANTITY_PACING_OFS, 32'h5);
        rd(pacing_pkg::FLOW_QUANTITY_PACING_OFS, 32'hA);
        wr(pacing_pkg::FLOW_QUANTITY_PACING_OFS, 32'h1E8481);
        rd(pacing_pkg::FLOW_QUANTITY_PACING_OFS, 32'hF4240);
        wr(pacing_pkg::FLOW_QUANTITY_PACING_OFS, 32'h1E);
        wr(pacing_pkg::MODE_OFS, 32'h1);
        base = smp_u.pulses;
        ticks(6, 32'h14);
        chk(32'(smp_u.pulses - base), 32'h4);
        chk(32'(smp_u.taken), 32'h1);
        $display("test flow_quantity_pacing done");
        sensor_enabled <= 8'h1B;
        wr(pacing_pkg::COND_A_OFS, 32'h2);
        rd(pacing_pkg::COND_A_OFS, 32'h0);
        wr(pacing_pkg::COND_A_OFS, 32'h3);
        wr(pacing_pkg::COND_B_OFS, 32'h4);
        rd(pacing_pkg::COND_B_OFS, 32'h0);
        wr(pacing_pkg::COND_A_OFS, 32'h0);
        wr(pacing_pkg::COND_B_OFS, 32'h11);
        wr(pacing_pkg::LIMIT_A_OFS, 32'h64);
        wr(pacing_pkg::LIMIT_B_OFS, 32'h64);
        // Condition A is source 0 above 100, condition B is source 1 below 100.
        for (int c = 0; c < 3; c++) begin
            for (int k = 0; k < 4; k++) begin
                samples <= {96'h0, (k[1] ? 16'h0032 : 16'h00C8), (k[0] ? 16'h00C8 : 16'h0032)};
                wr(pacing_pkg::MODE_OFS, {28'h0, 2'(c), 2'h3});
                repeat (4) @(posedge clock);
                xfer(pacing_pkg::STATUS_OFS, 1'b0, 32'h0, 1'b0, q);
                chk({31'h0, q[1]}, {31'h0, (c == 0) ? k[0] : (c == 1) ? (k[0] | k[1]) : (k[0] & k[1])});
            end
        end
        wr(pacing_pkg::MODE_OFS, 32'h3);
        for (int k = 0; k < 4; k++) begin
            wr(pacing_pkg::INTERVAL_OFS, iv[k]);
            samples <= {112'h0, ((k == 0 || k == 3) ? 16'h00C8 : 16'h0032)};
            repeat (25) @(posedge clock);
            base = smp_u.pulses;
            repeat (100) @(posedge clock);
            chk(32'(smp_u.pulses - base), (k == 0 || k == 2) ? 32'h5 : 32'h0);
        end
        // Slope on source 0: amount 16 over one minute, baseline taken each minute.
        wr(pacing_pkg::SLOPE_T_OFS, 32'h1);
        wr(pacing_pkg::LIMIT_A_OFS, 32'h10);
        wr(pacing_pkg::COND_A_OFS, 32'h20);
        samples <= {112'h0, 16'h0032};
        repeat (30) @(posedge clock);
        samples <= {112'h0, 16'h0080};
        repeat (2) @(posedge clock);
        xfer(pacing_pkg::STATUS_OFS, 1'b0, 32'h0, 1'b0, q);
        chk({31'h0, q[1]}, 32'h1);
        repeat (30) @(posedge clock);
        xfer(pacing_pkg::STATUS_OFS, 1'b0, 32'h0, 1'b0, q);
        chk({31'h0, q[1]}, 32'h0);
        $display("test conditions done");
        @(posedge clock);
        host_write <= 1'b1;
        host_addr <= pacing_pkg::MODE_OFS;
        host_wdata <= 32'h12;
        @(posedge clock);
        host_write <= 1'b0;
        xfer(pacing_pkg::MODE_OFS, 1'b1, 32'h0, 1'b1, q);
        rd(pacing_pkg::MODE_OFS, 32'h12);
        $display("test host lock done");
        close_out();
    end
endmodule : sampler_pacing_pulse_logic_tb
